// *** rtl/ldc_pkg.sv ***
// shared constants and types for the low side driver control block
package ldc_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned SC_BLANK_NS   = 20_000;
  localparam int unsigned INRUSH_NS     = 200_000;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int unsigned SC_BLANK_CYC  = (SC_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned INRUSH_CYC    = (INRUSH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RETRY_MULT    = 100;

  // modulator
  localparam int unsigned PWM_STEPS     = 100;
  localparam int unsigned PWM_SLOW_HZ   = 100;
  localparam int unsigned PWM_FAST_HZ   = 1_000;
  localparam int unsigned SLOW_STEP_CYC = CLK_HZ / (PWM_SLOW_HZ * PWM_STEPS);
  localparam int unsigned FAST_STEP_CYC = CLK_HZ / (PWM_FAST_HZ * PWM_STEPS);
  localparam logic [6:0]  DUTY_FULL     = 7'h64;
  localparam logic [6:0]  STEP_LAST     = 7'h63;

  // modulation source field
  typedef enum logic [1:0] {
    PWM_NONE = 2'h0,
    PWM_SLOW = 2'h1,
    PWM_FAST = 2'h2,
    PWM_EXT  = 2'h3
  } ldc_pwm_mode_t;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL_ON   = 8'h00;
  localparam logic [7:0] OFS_CFG_OR    = 8'h04;
  localparam logic [7:0] OFS_CFG_RETRY = 8'h08;
  localparam logic [7:0] OFS_CFG_INR   = 8'h0C;
  localparam logic [7:0] OFS_CFG_PDN   = 8'h10;
  localparam logic [7:0] OFS_ST_OC     = 8'h20;
  localparam logic [7:0] OFS_ST_OT     = 8'h24;
  localparam logic [7:0] OFS_ST_SG     = 8'h28;
  localparam logic [7:0] OFS_ST_OL     = 8'h2C;
  localparam logic [7:0] OFS_SUMMARY   = 8'h30;
  localparam logic [7:0] OFS_INT_MASK  = 8'h34;
  localparam logic [7:0] OFS_ON_STATE  = 8'h38;
  localparam logic [7:0] OFS_PWM_BASE  = 8'h40;

  // field positions in the per-channel modulator register and the summary register
  localparam int unsigned PWM_MODE_LSB = 0;
  localparam int unsigned PWM_DUTY_LSB = 8;
  localparam int unsigned SUMMARY_ANY  = 31;

  // comparator flags of one output
  typedef struct packed {
    logic oc;
    logic ot;
    logic sg;
    logic ol;
  } ldc_flags_t;

endpackage : ldc_pkg

// *** rtl/ldc_sync.sv ***
// two flop synchroniser for a vector of levels
`timescale 1ns/100ps
module ldc_sync #(
  parameter int unsigned W = 4
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : ldc_sync

// *** rtl/ldc_chan.sv ***
// overcurrent blanking, retry and latch-off for one output
`timescale 1ns/100ps
module ldc_chan #(
  parameter int unsigned BLANK_CYC  = 1000,
  parameter int unsigned INRUSH_CYC = 10000,
  parameter int unsigned RETRY_MULT = 100
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // control
  input  wire logic cmd,
  input  wire logic oc,
  input  wire logic retry_en,
  input  wire logic inrush_en,
  // result
  output logic      run,
  output logic      oc_evt
);
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_RUN   = 4'h2,
    ST_COOL  = 4'h4,
    ST_LATCH = 4'h8
  } ldc_chan_st_t;

  ldc_chan_st_t state_reg;
  logic [31:0]  cnt_reg;
  logic [31:0]  lim;
  logic [31:0]  cool_lim;

  assign lim      = inrush_en ? 32'(INRUSH_CYC) : 32'(BLANK_CYC);
  assign cool_lim = 32'(lim * RETRY_MULT);
  assign run      = (state_reg == ST_RUN);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= '0;
      oc_evt    <= 1'b0;
    end else begin
      oc_evt <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          cnt_reg <= '0;
          if (cmd) state_reg <= ST_RUN;
        end
        ST_RUN: begin
          if (!cmd) begin
            state_reg <= ST_IDLE;
          end else if (oc) begin
            cnt_reg <= cnt_reg + 32'h1;
            if (cnt_reg >= lim - 32'h1) begin
              oc_evt    <= 1'b1;
              cnt_reg   <= '0;
              state_reg <= retry_en ? ST_COOL : ST_LATCH;
            end
          end else begin
            cnt_reg <= '0;
          end
        end
        ST_COOL: begin
          cnt_reg <= cnt_reg + 32'h1;
          if (!cmd) begin
            state_reg <= ST_IDLE;
          end else if (cnt_reg >= cool_lim - 32'h1) begin
            cnt_reg   <= '0;
            state_reg <= ST_RUN;
          end
        end
        ST_LATCH: begin
          if (!cmd) state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule : ldc_chan

// *** rtl/ldc_top.sv ***
// low side driver control: command logic, modulator, protection, status, apb
// What this block does
// - key switch low forces every output off except the second relay output.
// - reset line low forces all outputs off, second relay included.
// - command is pin OR bit, or pin AND bit, chosen per output; bit alone in pin clocked mode.
// - two-bit mode picks none/pin, 100 Hz, 1 kHz or pin divided by 100.
// - seven-bit duty in 1% steps; codes 100 to 127 mean full on.
// - retry on: limit for blank time, off 100 times that, then retry.
// - retry off: overcurrent latches output off until command cycles off-on.
// - inrush bit stretches overcurrent blanking to the inrush interval.
// - overtemperature forces output off until the flag clears while still commanded.
// - thermal limit always active, auto retry, no register alters it.
// - drivers report oc, ot, sg, ol; tach no sg; pre-drivers ol, oc.
// - summary bit for any fault plus per-output any-fault indication.
// - pull-down disabled forces that output's open-load status to zero.
// - open load checked only while off, short only while on.
// - fault status bits stay set until software clears them or reset.
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/100ps
module ldc_top #(
  parameter int unsigned N_CH          = 9,
  parameter int unsigned RELAY2_IDX    = 4,
  parameter int unsigned TACH_IDX      = 5,
  parameter int unsigned PRE_FIRST     = 6,
  parameter int unsigned BLANK_CYC     = ldc_pkg::SC_BLANK_CYC,
  parameter int unsigned INRUSH_CYC    = ldc_pkg::INRUSH_CYC,
  parameter int unsigned SLOW_STEP_CYC = ldc_pkg::SLOW_STEP_CYC,
  parameter int unsigned FAST_STEP_CYC = ldc_pkg::FAST_STEP_CYC
) (
  // apb
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // system pins
  input  wire logic                          key_switch_input,
  input  wire logic                          system_reset_line_n,
  input  wire logic [N_CH-1:0]               in_pin,
  // analog comparator flags
  input  wire ldc_pkg::ldc_flags_t [N_CH-1:0] cmp_flags,
  // driver gates and interrupt
  output logic      [N_CH-1:0]               low_side_switch,
  output logic                               irq
);

  // register state
  logic [N_CH-1:0]       ctrl_on_reg;
  logic [N_CH-1:0]       cfg_or_reg;
  logic [N_CH-1:0]       cfg_retry_reg;
  logic [N_CH-1:0]       cfg_inr_reg;
  logic [N_CH-1:0]       cfg_pdn_reg;
  logic [N_CH-1:0]       int_mask_reg;
  logic [N_CH-1:0]       st_oc_reg;
  logic [N_CH-1:0]       st_ot_reg;
  logic [N_CH-1:0]       st_sg_reg;
  logic [N_CH-1:0]       st_ol_reg;
  logic [N_CH-1:0][1:0]  pwm_mode_reg;
  logic [N_CH-1:0][6:0]  pwm_duty_reg;

  // internal
  ldc_pkg::ldc_flags_t [N_CH-1:0] flg_s;
  logic [N_CH-1:0] cmd;
  logic [N_CH-1:0] run;
  logic [N_CH-1:0] oc_evt;
  logic [N_CH-1:0] gate;
  logic [N_CH-1:0] on_next;
  logic [N_CH-1:0] set_oc;
  logic [N_CH-1:0] set_ot;
  logic [N_CH-1:0] set_sg;
  logic [N_CH-1:0] set_ol;
  logic [N_CH-1:0] any_ch;
  logic [N_CH-1:0] sg_cap;
  logic [N_CH-1:0] ot_cap;
  logic [N_CH-1:0] pin_q_reg;
  logic [31:0]     slow_cnt_reg;
  logic [31:0]     fast_cnt_reg;
  logic            slow_tick;
  logic            fast_tick;
  logic            acc;
  logic            wr;
  logic [31:0]     rd_data;
  logic            rd_err;
  logic [5:0]      pwm_idx;
  logic [7:0]      pwm_end;

  // flag synchroniser
  ldc_sync #(
    .W ($bits(cmp_flags))
  ) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (cmp_flags),
    .q     (flg_s)
  );

  // apb handshake, one wait state
  assign acc     = psel & penable;
  assign wr      = acc & pwrite & pready;
  assign pwm_end = 8'(ldc_pkg::OFS_PWM_BASE + 8'(N_CH * 4));
  assign pwm_idx = 6'((paddr - ldc_pkg::OFS_PWM_BASE) >> 2);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc & ~pready;
      pslverr <= acc & ~pready & rd_err;
      if (acc & ~pready & ~pwrite) begin
        prdata <= rd_data;
      end
    end
  end

  // read mux and decode
  always_comb begin
    rd_data = '0;
    rd_err  = 1'b0;
    case (paddr)
      ldc_pkg::OFS_CTRL_ON:   rd_data[N_CH-1:0] = ctrl_on_reg;
      ldc_pkg::OFS_CFG_OR:    rd_data[N_CH-1:0] = cfg_or_reg;
      ldc_pkg::OFS_CFG_RETRY: rd_data[N_CH-1:0] = cfg_retry_reg;
      ldc_pkg::OFS_CFG_INR:   rd_data[N_CH-1:0] = cfg_inr_reg;
      ldc_pkg::OFS_CFG_PDN:   rd_data[N_CH-1:0] = cfg_pdn_reg;
      ldc_pkg::OFS_ST_OC:     rd_data[N_CH-1:0] = st_oc_reg;
      ldc_pkg::OFS_ST_OT:     rd_data[N_CH-1:0] = st_ot_reg;
      ldc_pkg::OFS_ST_SG:     rd_data[N_CH-1:0] = st_sg_reg;
      ldc_pkg::OFS_ST_OL:     rd_data[N_CH-1:0] = st_ol_reg;
      ldc_pkg::OFS_INT_MASK:  rd_data[N_CH-1:0] = int_mask_reg;
      ldc_pkg::OFS_ON_STATE:  rd_data[N_CH-1:0] = low_side_switch;
      ldc_pkg::OFS_SUMMARY: begin
        rd_data[N_CH-1:0]               = any_ch;
        rd_data[ldc_pkg::SUMMARY_ANY]   = |any_ch;
      end
      default: begin
        if (paddr >= ldc_pkg::OFS_PWM_BASE && paddr < pwm_end && paddr[1:0] == 2'h0) begin
          rd_data[ldc_pkg::PWM_MODE_LSB +: 2] = pwm_mode_reg[pwm_idx];
          rd_data[ldc_pkg::PWM_DUTY_LSB +: 7] = pwm_duty_reg[pwm_idx];
        end else begin
          rd_err = 1'b1;
        end
      end
    endcase
  end

  // control and configuration writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_on_reg   <= '0;
      cfg_or_reg    <= '0;
      cfg_retry_reg <= '1;
      cfg_inr_reg   <= '0;
      cfg_pdn_reg   <= '1;
      int_mask_reg  <= '0;
    end else if (wr) begin
      case (paddr)
        ldc_pkg::OFS_CTRL_ON:   ctrl_on_reg   <= pwdata[N_CH-1:0];
        ldc_pkg::OFS_CFG_OR:    cfg_or_reg    <= pwdata[N_CH-1:0];
        ldc_pkg::OFS_CFG_RETRY: cfg_retry_reg <= pwdata[N_CH-1:0];
        ldc_pkg::OFS_CFG_INR:   cfg_inr_reg   <= pwdata[N_CH-1:0];
        ldc_pkg::OFS_CFG_PDN:   cfg_pdn_reg   <= pwdata[N_CH-1:0];
        ldc_pkg::OFS_INT_MASK:  int_mask_reg  <= pwdata[N_CH-1:0];
        default: ;
      endcase
    end
  end

  // per-channel modulator registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_mode_reg <= '0;
      pwm_duty_reg <= '0;
    end else if (wr && paddr >= ldc_pkg::OFS_PWM_BASE && paddr < pwm_end
                 && paddr[1:0] == 2'h0) begin
      pwm_mode_reg[pwm_idx] <= pwdata[ldc_pkg::PWM_MODE_LSB +: 2];
      pwm_duty_reg[pwm_idx] <= pwdata[ldc_pkg::PWM_DUTY_LSB +: 7];
    end
  end

  // step prescalers for the two internal rates
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_cnt_reg <= '0;
      fast_cnt_reg <= '0;
    end else begin
      slow_cnt_reg <= slow_tick ? '0 : slow_cnt_reg + 32'h1;
      fast_cnt_reg <= fast_tick ? '0 : fast_cnt_reg + 32'h1;
    end
  end
  assign slow_tick = (slow_cnt_reg == 32'(SLOW_STEP_CYC - 1));
  assign fast_tick = (fast_cnt_reg == 32'(FAST_STEP_CYC - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pin_q_reg <= '0;
    else          pin_q_reg <= in_pin;
  end

  // per-channel command, modulator and protection
  genvar gi;
  generate
    for (gi = 0; gi < N_CH; gi++) begin : g_ch
      logic [6:0] step_reg;
      logic [6:0] duty_c;
      logic       step_tick;
      logic       pwm_hi;
      logic       comb;

      assign comb   = cfg_or_reg[gi] ? (in_pin[gi] | ctrl_on_reg[gi])
                                     : (in_pin[gi] & ctrl_on_reg[gi]);
      assign duty_c = (pwm_duty_reg[gi] > ldc_pkg::DUTY_FULL) ? ldc_pkg::DUTY_FULL
                                                              : pwm_duty_reg[gi];
      assign pwm_hi = (step_reg < duty_c);

      always_comb begin
        case (ldc_pkg::ldc_pwm_mode_t'(pwm_mode_reg[gi]))
          ldc_pkg::PWM_SLOW: step_tick = slow_tick;
          ldc_pkg::PWM_FAST: step_tick = fast_tick;
          ldc_pkg::PWM_EXT:  step_tick = in_pin[gi] & ~pin_q_reg[gi];
          default:           step_tick = 1'b0;
        endcase
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          step_reg <= '0;
        end else if (step_tick) begin
          step_reg <= (step_reg >= ldc_pkg::STEP_LAST) ? 7'h00 : step_reg + 7'h01;
        end
      end

      always_comb begin
        case (ldc_pkg::ldc_pwm_mode_t'(pwm_mode_reg[gi]))
          ldc_pkg::PWM_SLOW: cmd[gi] = comb & pwm_hi;
          ldc_pkg::PWM_FAST: cmd[gi] = comb & pwm_hi;
          ldc_pkg::PWM_EXT:  cmd[gi] = ctrl_on_reg[gi] & pwm_hi;
          default:           cmd[gi] = comb;
        endcase
      end

      ldc_chan #(
        .BLANK_CYC  (BLANK_CYC),
        .INRUSH_CYC (INRUSH_CYC),
        .RETRY_MULT (ldc_pkg::RETRY_MULT)
      ) u_chan (
        .clk       (pclk),
        .rst_n     (presetn),
        .cmd       (cmd[gi]),
        .oc        (flg_s[gi].oc),
        .retry_en  (cfg_retry_reg[gi]),
        .inrush_en (cfg_inr_reg[gi]),
        .run       (run[gi]),
        .oc_evt    (oc_evt[gi])
      );

      // gating by key switch and reset line
      assign gate[gi] = system_reset_line_n
                        & (key_switch_input | (gi == RELAY2_IDX));
      assign on_next[gi] = run[gi] & ~flg_s[gi].ot & gate[gi];

      // which fault kinds this output reports
      assign ot_cap[gi] = (gi < PRE_FIRST);
      assign sg_cap[gi] = (gi < PRE_FIRST) && (gi != TACH_IDX);

      assign set_oc[gi] = oc_evt[gi];
      assign set_ot[gi] = ot_cap[gi] & flg_s[gi].ot;
      assign set_sg[gi] = sg_cap[gi] & flg_s[gi].sg & low_side_switch[gi];
      assign set_ol[gi] = flg_s[gi].ol & ~low_side_switch[gi] & cfg_pdn_reg[gi];
    end
  endgenerate

  // driver outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) low_side_switch <= '0;
    else          low_side_switch <= on_next;
  end

  // sticky fault status, set wins over write-one-to-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_oc_reg <= '0;
      st_ot_reg <= '0;
      st_sg_reg <= '0;
    end else begin
      st_oc_reg <= (st_oc_reg & ~((wr && paddr == ldc_pkg::OFS_ST_OC) ? pwdata[N_CH-1:0] : '0))
                   | set_oc;
      st_ot_reg <= (st_ot_reg & ~((wr && paddr == ldc_pkg::OFS_ST_OT) ? pwdata[N_CH-1:0] : '0))
                   | set_ot;
      st_sg_reg <= (st_sg_reg & ~((wr && paddr == ldc_pkg::OFS_ST_SG) ? pwdata[N_CH-1:0] : '0))
                   | set_sg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ol_reg <= '0;
    end else begin
      st_ol_reg <= ((st_ol_reg & ~((wr && paddr == ldc_pkg::OFS_ST_OL) ? pwdata[N_CH-1:0] : '0))
                   | set_ol) & cfg_pdn_reg;
    end
  end

  // per-output any fault and interrupt
  assign any_ch = st_oc_reg | st_ot_reg | st_sg_reg | st_ol_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq <= 1'b0;
    else          irq <= |(any_ch & int_mask_reg);
  end

endmodule : ldc_top

// *** tb/ldc_top_asserts.sv ***
// concurrent checks on the low side driver control ports
`timescale 1ns/100ps
module ldc_top_asserts #(
  parameter int unsigned N_CH       = 9,
  parameter int unsigned RELAY2_IDX = 4,
  parameter int unsigned PRE_FIRST  = 6
) (
  // apb
  input wire logic                           pclk,
  input wire logic                           presetn,
  input wire logic                           psel,
  input wire logic                           penable,
  input wire logic                           pwrite,
  input wire logic                           pready,
  input wire logic                           pslverr,
  // system pins
  input wire logic                           key_switch_input,
  input wire logic                           system_reset_line_n,
  input wire ldc_pkg::ldc_flags_t [N_CH-1:0] cmp_flags,
  // outputs
  input wire logic [N_CH-1:0]                low_side_switch,
  input wire logic                           irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic [N_CH-1:0] relay_m;
  assign relay_m = {{(N_CH-1){1'b0}}, 1'b1} << RELAY2_IDX;

  a_key_gate: assert property (!key_switch_input |=> (low_side_switch & ~relay_m) == '0)
    else $error("output on with key switch low");
  a_line_off: assert property (!system_reset_line_n |=> low_side_switch == '0)
    else $error("output on with reset line low");
  a_irq_sticky: assert property ($fell(irq) |-> $past(pwrite && penable) ||
      $past(pwrite && penable, 2) || $past(pwrite && penable, 3) || !$past(system_reset_line_n, 2))
    else $error("interrupt dropped without a write");
  a_pready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("no ready after one wait state");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error response without ready");
  for (genvar i = 0; i < N_CH; i++) begin : g_ch
    a_on_gate: assert property ($rose(low_side_switch[i]) |-> $past(system_reset_line_n) &&
        ($past(key_switch_input) || i == RELAY2_IDX))
      else $error("output turned on while gated");
    if (i < PRE_FIRST) begin : g_lsd
      a_ot_off: assert property (cmp_flags[i].ot [*5] |-> !low_side_switch[i])
        else $error("output on during overtemperature");
      a_ot_norise: assert property ($rose(low_side_switch[i]) |-> !$past(cmp_flags[i].ot, 3))
        else $error("output restarted while hot");
    end
  end
  c_relay_kept: cover property (!key_switch_input && low_side_switch[RELAY2_IDX]);
  c_irq: cover property ($rose(irq));
  c_slverr: cover property (pready && pslverr);
endmodule : ldc_top_asserts

bind ldc_top ldc_top_asserts #(.N_CH(N_CH), .RELAY2_IDX(RELAY2_IDX), .PRE_FIRST(PRE_FIRST)) u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .pready, .pslverr, .key_switch_input,
  .system_reset_line_n, .cmp_flags, .low_side_switch, .irq);

// *** tb/ldc_host_model.sv ***
// host side pin model: pin levels and a pin clock on pin 0
`timescale 1ns/100ps
module ldc_host_model (
  // clock
  input wire logic       pclk,
  // requests from the bench
  input wire logic [8:0] pin_lvl,
  input wire logic       ext_clk_en,
  // input pins of the block
  output logic     [8:0] in_pin
);
  logic [1:0] div_cnt = 2'h0;

  // free running divider, pin clock period four cycles
  always_ff @(posedge pclk) begin
    div_cnt <= div_cnt + 2'h1;
  end

  // host puts the modulating waveform on the channel's own pin
  assign in_pin = ext_clk_en ? {pin_lvl[8:1], div_cnt[1]} : pin_lvl;
endmodule : ldc_host_model

// *** tb/tb_ldc_top.sv ***
// self-checking bench for the low side driver control block
`timescale 1ns/100ps
module tb_ldc_top;
  localparam int BLK = 4;
  localparam int INR = 8;
  logic                      pclk;
  logic                      presetn;
  logic                      psel;
  logic                      penable;
  logic                      pwrite;
  logic [7:0]                paddr;
  logic [31:0]               pwdata;
  logic [31:0]               prdata;
  logic                      pready;
  logic                      pslverr;
  logic                      key_switch_input;
  logic                      system_reset_line_n;
  logic [8:0]                in_pin;
  logic [8:0]                pin_lvl;
  logic                      ext_clk_en;
  ldc_pkg::ldc_flags_t [8:0] cmp_flags;
  logic [8:0]                low_side_switch;
  logic                      irq;
  logic [31:0]               rd;
  logic                      last_err;
  logic [8:0]                orv;
  logic [8:0]                onv;
  logic [6:0]                duty_tab [4] = '{7'h00, 7'h25, 7'h64, 7'h7F};
  int                        step_tab [4] = '{0, 5, 3, 4};
  int                        error_cnt;
  int                        checks;
  int                        seed;
  int                        n0;
  int                        n1;
  int                        k;

  ldc_host_model host (.pclk, .pin_lvl, .ext_clk_en, .in_pin);
  ldc_top #(.BLANK_CYC(BLK), .INRUSH_CYC(INR), .SLOW_STEP_CYC(5), .FAST_STEP_CYC(3)) uut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .key_switch_input, .system_reset_line_n, .in_pin, .cmp_flags, .low_side_switch, .irq);

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic conclude();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr_en;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk(32'(n < 20), 32'h1);
    if (n >= 20) conclude();
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick

  task automatic neg_chk(input logic [31:0] e, input int sel);
    @(negedge pclk);
    chk(sel == 0 ? 32'(low_side_switch) : 32'(irq), e);
    @(posedge pclk);
  endtask : neg_chk

  task automatic wait_lvl(input int ch, input logic v, output int n);
    n = 0;
    while (low_side_switch[ch] !== v && n < 1000) begin
      @(negedge pclk);
      n++;
    end
    chk(32'(n < 1000), 32'h1);
    if (n >= 1000) conclude();
    @(posedge pclk);
  endtask : wait_lvl

  task automatic count_on(input int len, output int c);
    c = 0;
    repeat (len) begin
      @(negedge pclk);
      if (low_side_switch[0] === 1'b1) c++;
    end
  endtask : count_on

  function automatic logic [8:0] exp_cmd(input logic [8:0] o, input logic [8:0] on,
                                         input logic [8:0] p);
    return (o & (p | on)) | (~o & p & on);
  endfunction : exp_cmd

  function automatic int exp_on(input logic [6:0] d, input int st);
    return ((d > 7'h64) ? 100 : int'(d)) * st;
  endfunction : exp_on

  initial begin
    tick(100000);
    error_cnt++;
    conclude();
  end

  initial begin
    seed = 61090;
    error_cnt = 0;
    checks = 0;
    {presetn, psel, penable, pwrite, paddr, pwdata, ext_clk_en} = '0;
    {key_switch_input, system_reset_line_n} = 2'h3;
    pin_lvl = 9'h000;
    cmp_flags = '0;
    tick(10);
    presetn <= 1'b1;
    // reset values, unmapped holes
    rdc(ldc_pkg::OFS_CFG_RETRY, 32'h0000_01FF);
    rdc(ldc_pkg::OFS_CFG_PDN, 32'h0000_01FF);
    rdc(ldc_pkg::OFS_CFG_OR, 32'h0);
    rdc(8'h1C, 32'h0);
    chk(32'(last_err), 32'h1);
    wr(8'h3C, 32'hFFFF_FFFF);
    chk(32'(last_err), 32'h1);
    // random pin and bit combinations
    repeat (8) begin
      orv = 9'($random(seed));
      onv = 9'($random(seed));
      wr(ldc_pkg::OFS_CFG_OR, {23'h0, orv});
      wr(ldc_pkg::OFS_CTRL_ON, {23'h0, onv});
      pin_lvl <= 9'($random(seed));
      tick(4);
      neg_chk(32'(exp_cmd(orv, onv, pin_lvl)), 0);
      rdc(ldc_pkg::OFS_ON_STATE, 32'(exp_cmd(orv, onv, pin_lvl)));
    end
    pin_lvl <= 9'h000;
    wr(ldc_pkg::OFS_CFG_OR, 32'h1FF);
    wr(ldc_pkg::OFS_CTRL_ON, 32'h1FF);
    key_switch_input <= 1'b0;
    tick(3);
    neg_chk(32'h010, 0);
    system_reset_line_n <= 1'b0;
    tick(3);
    neg_chk(32'h000, 0);
    {key_switch_input, system_reset_line_n} <= 2'h3;
    // internal and pin clocked modulation
    wr(ldc_pkg::OFS_CTRL_ON, 32'h1);
    ext_clk_en <= 1'b1;
    for (int m = 1; m < 4; m++) begin
      for (int j = 0; j < 4; j++) begin
        wr(ldc_pkg::OFS_PWM_BASE, {17'h0, duty_tab[j], 6'h0, 2'(m)});
        tick(100 * step_tab[m]);
        count_on(100 * step_tab[m], k);
        chk(32'(k), 32'(exp_on(duty_tab[j], step_tab[m])));
      end
    end
    rdc(ldc_pkg::OFS_PWM_BASE, 32'h0000_7F03);
    wr(ldc_pkg::OFS_PWM_BASE, 32'h0);
    ext_clk_en <= 1'b0;
    // overcurrent retry, inrush, latch-off
    wr(ldc_pkg::OFS_CTRL_ON, 32'h2);
    tick(4);
    cmp_flags[1].oc <= 1'b1;
    wait_lvl(1, 1'b0, n0);
    cmp_flags[1].oc <= 1'b0;
    wait_lvl(1, 1'b1, n1);
    chk(32'(n1 >= 100 * BLK - 4 && n1 <= 100 * BLK + 4), 32'h1);
    wr(ldc_pkg::OFS_CFG_INR, 32'h2);
    tick(4);
    cmp_flags[1].oc <= 1'b1;
    wait_lvl(1, 1'b0, n1);
    chk(32'(n1 - n0), 32'(INR - BLK));
    cmp_flags[1].oc <= 1'b0;
    wait_lvl(1, 1'b1, n1);
    rdc(ldc_pkg::OFS_ST_OC, 32'h2);
    neg_chk(32'h0, 1);
    wr(ldc_pkg::OFS_INT_MASK, 32'h2);
    tick(3);
    neg_chk(32'h1, 1);
    wr(ldc_pkg::OFS_ST_OC, 32'h2);
    tick(3);
    neg_chk(32'h0, 1);
    wr(ldc_pkg::OFS_CFG_RETRY, 32'h1FD);
    cmp_flags[1].oc <= 1'b1;
    wait_lvl(1, 1'b0, n1);
    cmp_flags[1].oc <= 1'b0;
    tick(600);
    neg_chk(32'h000, 0);
    wr(ldc_pkg::OFS_CTRL_ON, 32'h0);
    wr(ldc_pkg::OFS_CTRL_ON, 32'h2);
    wait_lvl(1, 1'b1, n1);
    // overtemperature shutdown and restart
    wr(ldc_pkg::OFS_CTRL_ON, 32'h6);
    tick(4);
    cmp_flags[2].ot <= 1'b1;
    tick(6);
    neg_chk(32'h002, 0);
    rdc(ldc_pkg::OFS_ST_OT, 32'h4);
    cmp_flags[2].ot <= 1'b0;
    wait_lvl(2, 1'b1, n1);
    // fault reporting per channel kind
    wr(ldc_pkg::OFS_CTRL_ON, 32'h62);
    tick(4);
    cmp_flags[3] <= 4'h3;
    cmp_flags[5].sg <= 1'b1;
    cmp_flags[6] <= 4'h6;
    cmp_flags[1].sg <= 1'b1;
    tick(6);
    rdc(ldc_pkg::OFS_ST_SG, 32'h2);
    rdc(ldc_pkg::OFS_ST_OL, 32'h8);
    rdc(ldc_pkg::OFS_ST_OT, 32'h4);
    wr(ldc_pkg::OFS_CFG_PDN, 32'h1F7);
    tick(3);
    rdc(ldc_pkg::OFS_ST_OL, 32'h0);
    rdc(ldc_pkg::OFS_SUMMARY, 32'h8000_0006);
    conclude();
  end
endmodule : tb_ldc_top
